// ===== rtl/occ_pkg.sv
// package: constants shared by both ends of the checksum adder link
`default_nettype none
package occ_pkg;
	localparam int OCC_WORD_W = 16;
	localparam int OCC_BYTE_W = 8;
	localparam logic [15:0] OCC_ACC_RESET = 16'h0000;
	localparam logic [1:0] OCC_MC_DIV = 2'h3;
	localparam logic OCC_PTR_HIGH = 1'b0;
	localparam logic OCC_PTR_LOW = 1'b1;
endpackage : occ_pkg
`default_nettype wire

// ===== rtl/occ_if.sv
// interface: byte data port between core and checksum adder
`default_nettype none
interface occ_if;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic mc_tick;
	modport adder (input wr_stb, input rd_stb, input wr_data, output rd_data, output mc_tick);
	modport core (output wr_stb, output rd_stb, output wr_data, input rd_data, input mc_tick);
endinterface : occ_if
`default_nettype wire

// ===== rtl/occ_adder.sv
// checksum adder device end: byte port, accumulator, machine-cycle divider
//
// Summary of operation
// - one 16-bit accumulator holds running sum
// - two byte writes form operand, then add
// - writer sends high byte before low byte
// - add on next machine cycle, single cycle
// - back-to-back word pairs accepted without stall
// - carry out of bit 15 wraps to bit 0
// - two reads return high then low byte
// - second read clears accumulator to zero
// - software reads twice first, then writes words
// - software inverts read bytes for checksum
// - summing message plus checksum gives ffff
// - machine cycle is system clock divided by four
`default_nettype none
module occ_adder
	import occ_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	occ_if.adder port,
	output logic [15:0] acc_value,
	output logic add_busy
);

	// ----------------------------------------
	// machine cycle divider
	// ----------------------------------------
	logic [1:0] mc_cnt_reg;
	logic mc_tick;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			mc_cnt_reg <= 2'h0;
		else
			mc_cnt_reg <= mc_cnt_reg + 2'h1;
	end

	// ----------------------------------------
	// machine cycle tick
	// ----------------------------------------
	// one tick per four core clocks times every add
	assign mc_tick = (mc_cnt_reg == OCC_MC_DIV);
	assign port.mc_tick = mc_tick;

	// ----------------------------------------
	// shared state
	// ----------------------------------------
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [7:0] hi_byte_reg;
	logic [15:0] operand_reg;
	logic pend_reg;
	logic [15:0] acc_reg;
	logic [7:0] lo_hold_reg;
	logic [7:0] rd_data_reg;
	logic pair_done;
	logic clear_now;
	logic add_now;
	logic [15:0] new_word;
	logic [16:0] merge_full;
	logic [15:0] merge_wrap;
	logic [16:0] sum_full;
	logic [15:0] sum_wrap;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// order is trusted, not checked
	assign pair_done = port.wr_stb && (wr_ptr_reg == OCC_PTR_LOW);
	assign new_word = {hi_byte_reg, port.wr_data};

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	assign clear_now = port.rd_stb && (rd_ptr_reg == OCC_PTR_LOW);
	// a clear in the tick cycle defers the add rather than losing it
	assign add_now = pend_reg && mc_tick && !clear_now;

	// ----------------------------------------
	// write pointer
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			wr_ptr_reg <= OCC_PTR_HIGH;
		else if (port.wr_stb)
			wr_ptr_reg <= ~wr_ptr_reg;
	end

	// ----------------------------------------
	// high byte latch
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			hi_byte_reg <= 8'h00;
		else if (port.wr_stb && wr_ptr_reg == OCC_PTR_HIGH)
			hi_byte_reg <= port.wr_data;
	end

	// ----------------------------------------
	// operand merge adder
	// ----------------------------------------
	// one wrap step suffices: with a carry the low half is at most fffe
	assign merge_full = {1'b0, operand_reg} + {1'b0, new_word};
	assign merge_wrap = merge_full[15:0] + {15'h0000, merge_full[16]};

	// ----------------------------------------
	// accumulator adder
	// ----------------------------------------
	assign sum_full = {1'b0, acc_reg} + {1'b0, operand_reg};
	assign sum_wrap = sum_full[15:0] + {15'h0000, sum_full[16]};

	// ----------------------------------------
	// pending operand
	// ----------------------------------------
	// a pair landing before the tick folds into the waiting one, so
	// back-to-back words cost a second adder but never overwrite
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			operand_reg <= 16'h0000;
		else if (pair_done)
		begin
			if (pend_reg && !add_now)
				operand_reg <= merge_wrap;
			else
				operand_reg <= new_word;
		end
	end

	// ----------------------------------------
	// pending flag
	// ----------------------------------------
	// set beats the tick that consumes the older operand
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			pend_reg <= 1'b0;
		else if (pair_done)
			pend_reg <= 1'b1;
		else if (add_now)
			pend_reg <= 1'b0;
	end

	// ----------------------------------------
	// accumulator
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			acc_reg <= OCC_ACC_RESET;
		else if (clear_now)
			acc_reg <= OCC_ACC_RESET;
		else if (add_now)
			acc_reg <= sum_wrap;
	end

	// ----------------------------------------
	// read pointer
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rd_ptr_reg <= OCC_PTR_HIGH;
		else if (port.rd_stb)
			rd_ptr_reg <= ~rd_ptr_reg;
	end

	// ----------------------------------------
	// low byte snapshot
	// ----------------------------------------
	// taken with the high read so both bytes belong to one sum
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			lo_hold_reg <= 8'h00;
		else if (port.rd_stb && rd_ptr_reg == OCC_PTR_HIGH)
			lo_hold_reg <= acc_reg[7:0];
	end

	// ----------------------------------------
	// read data register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rd_data_reg <= 8'h00;
		else if (port.rd_stb)
		begin
			if (rd_ptr_reg == OCC_PTR_HIGH)
				rd_data_reg <= acc_reg[15:8];
			else
				rd_data_reg <= lo_hold_reg;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign port.rd_data = rd_data_reg;
	assign acc_value = acc_reg;
	assign add_busy = pend_reg;

endmodule // occ_adder
`default_nettype wire

// ===== rtl/occ_core.sv
// checksum adder core end: drives word pairs and reads the sum back
`default_nettype none
module occ_core
	import occ_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	occ_if.core port,
	input wire logic word_valid,
	input wire logic [15:0] word_data,
	output logic word_ready,
	input wire logic sum_req,
	output logic sum_valid,
	output logic [15:0] sum_data,
	output logic [15:0] checksum
);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	typedef enum logic [2:0] {
		OCC_IDLE = 3'b000,
		OCC_WR_LO = 3'b001,
		OCC_RD_HI = 3'b010,
		OCC_RD_LO = 3'b011,
		OCC_RD_FIN = 3'b100
	} occ_state_t;

	occ_state_t state_reg;
	logic [7:0] lo_pend_reg;
	logic [7:0] hi_got_reg;
	logic add_wait_reg;

	assign word_ready = (state_reg == OCC_IDLE) && !sum_req;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= OCC_IDLE;
			lo_pend_reg <= 8'h00;
			hi_got_reg <= 8'h00;
			sum_data <= 16'h0000;
			sum_valid <= 1'b0;
		end
		else
		begin
			sum_valid <= 1'b0;
			unique case (state_reg)
				OCC_IDLE:
				begin
					if (sum_req)
					begin
						// a read must not overtake an add still waiting for its tick
						if (!add_wait_reg)
							state_reg <= OCC_RD_HI;
					end
					else if (word_valid)
					begin
						lo_pend_reg <= word_data[7:0];
						state_reg <= OCC_WR_LO;
					end
				end
				OCC_WR_LO: state_reg <= OCC_IDLE;
				OCC_RD_HI: state_reg <= OCC_RD_LO;
				OCC_RD_LO:
				begin
					hi_got_reg <= port.rd_data;
					state_reg <= OCC_RD_FIN;
				end
				OCC_RD_FIN:
				begin
					sum_data <= {hi_got_reg, port.rd_data};
					sum_valid <= 1'b1;
					state_reg <= OCC_IDLE;
				end
			endcase
		end
	end

	// mirrors the adder's pending flag: set by a low byte, cleared by the tick
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			add_wait_reg <= 1'b0;
		else if (state_reg == OCC_WR_LO)
			add_wait_reg <= 1'b1;
		else if (port.mc_tick)
			add_wait_reg <= 1'b0;
	end

	// high byte first, low byte next
	assign port.wr_stb = (state_reg == OCC_IDLE && !sum_req && word_valid)
		|| state_reg == OCC_WR_LO;
	assign port.wr_data = (state_reg == OCC_WR_LO) ? lo_pend_reg : word_data[15:8];
	// sum_req also used once at start to zero the sum
	assign port.rd_stb = (state_reg == OCC_RD_HI) || (state_reg == OCC_RD_LO);
	assign checksum = ~sum_data;

endmodule // occ_core
`default_nettype wire

// ===== tb/occ_monitor.sv
// checker for the byte port of the checksum adder
`default_nettype none
module occ_monitor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rd_data,
	input wire logic mc_tick,
	input wire logic [15:0] acc_value,
	input wire logic add_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// byte pointers rebuilt from strobes
	// ----
	logic wr_lo_reg;
	logic rd_lo_reg;
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_lo_reg <= 1'b0;
			rd_lo_reg <= 1'b0;
		end
		else
		begin
			wr_lo_reg <= wr_lo_reg ^ wr_stb;
			rd_lo_reg <= rd_lo_reg ^ rd_stb;
		end
	end
	logic pair_now;
	logic add_free;
	assign pair_now = wr_stb && wr_lo_reg;
	assign add_free = !rd_stb && !pair_now;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence quiet3;
		!mc_tick [*3];
	endsequence
	sequence pair_in;
		pair_now;
	endsequence
	sequence add_slot;
		add_busy ##[0:3] (add_busy && mc_tick);
	endsequence
	tick_period_a: assert property (mc_tick |=> quiet3 ##1 mc_tick)
		else $error("tick");
	add_due_a: assert property (pair_in |=> add_slot)
		else $error("add late");
	add_done_a: assert property (add_busy && mc_tick && add_free |=> !add_busy)
		else $error("add kept");
	busy_cause_a: assert property ($rose(add_busy) |-> $past(wr_stb) && $past(wr_lo_reg))
		else $error("busy");
	acc_hold_a: assert property (!(add_busy && mc_tick) && !rd_stb |=> $stable(acc_value))
		else $error("acc moved");
	rd_high_a: assert property (rd_stb && !rd_lo_reg |=> rd_data == $past(acc_value[15:8]))
		else $error("high byte");
	rd_stand_a: assert property (!rd_stb |=> $stable(rd_data))
		else $error("rd moved");
	rd_clear_a: assert property (rd_stb && rd_lo_reg |=> acc_value == 16'h0000)
		else $error("no clear");
	reset_clear_a: assert property ($past(sys_rst) |-> acc_value == 16'h0000 && !add_busy)
		else $error("reset");
endmodule // occ_monitor
`default_nettype wire

// ===== tb/ones_complement_checksum_adder_tb.sv
// self-checking bench for both ends of the checksum adder
`default_nettype none
module ones_complement_checksum_adder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic word_valid = 1'b0;
	logic [15:0] word_data = 16'h0000;
	logic sum_req = 1'b0;
	logic word_ready, sum_valid, add_busy;
	logic [15:0] sum_data, checksum, acc_value;
	logic [15:0] exp_acc = 16'h0000;
	logic [7:0] wq[$];
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	occ_if lk ();
	occ_adder i_occ_adder (.core_clk(core_clk), .sys_rst(sys_rst), .port(lk.adder),
		.acc_value(acc_value), .add_busy(add_busy));
	occ_core i_occ_core (.core_clk(core_clk), .sys_rst(sys_rst), .port(lk.core),
		.word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
		.sum_req(sum_req), .sum_valid(sum_valid), .sum_data(sum_data), .checksum(checksum));
	occ_monitor i_occ_monitor (.core_clk(core_clk), .sys_rst(sys_rst), .wr_stb(lk.wr_stb),
		.rd_stb(lk.rd_stb), .rd_data(lk.rd_data), .mc_tick(lk.mc_tick),
		.acc_value(acc_value), .add_busy(add_busy));
	always #10 core_clk = ~core_clk;
	// ----
	// wire capture and hang guard
	// ----
	// sampled on the rising edge, where the core's strobes have settled
	always @(posedge core_clk)
	begin
		cycles++;
		if (lk.wr_stb === 1'b1)
			wq.push_back(lk.wr_data);
		if (cycles == 3000)
		begin
			failures++;
			close_out();
		end
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one word, then six cycles so the add has landed before the compare
	task automatic send(input logic [15:0] w);
		logic [16:0] s;
		wq.delete();
		while (word_ready !== 1'b1)
			@(negedge core_clk);
		word_valid = 1'b1;
		word_data = w;
		@(negedge core_clk);
		word_valid = 1'b0;
		repeat (6) @(negedge core_clk);
		check("wire", {wq[0], wq[1]}, w);
		wq.delete();
		s = {1'b0, exp_acc} + {1'b0, w};
		exp_acc = s[15:0] + {15'h0000, s[16]};
		check("acc", acc_value, exp_acc);
	endtask
	task automatic read_sum();
		sum_req = 1'b1;
		while (sum_valid !== 1'b1)
			@(negedge core_clk);
		check("rdy", word_ready, 1'b0);
		sum_req = 1'b0;
		@(negedge core_clk);
		check("sum", sum_data, exp_acc);
		check("ck", checksum, ~exp_acc);
		check("clr", acc_value, 16'h0000);
		exp_acc = 16'h0000;
	endtask
	task automatic t_carry();
		send(16'hffff);
		send(16'h0002);
		read_sum();
		read_sum();
	endtask
	task automatic t_verify();
		logic [15:0] ck;
		send(16'h4500);
		send(16'h0030);
		ck = ~exp_acc;
		read_sum();
		send(16'h4500);
		send(16'h0030);
		send(ck);
		read_sum();
		check("verify", checksum, 16'h0000);
	endtask
	// words every second cycle, then a read at once: nothing may be lost
	task automatic t_burst();
		logic [15:0] w[3];
		logic [16:0] s;
		w = '{16'h8001, 16'h8001, 16'h1234};
		foreach (w[i])
		begin
			while (word_ready !== 1'b1)
				@(negedge core_clk);
			word_valid = 1'b1;
			word_data = w[i];
			@(negedge core_clk);
			word_valid = 1'b0;
			s = {1'b0, exp_acc} + {1'b0, w[i]};
			exp_acc = s[15:0] + {15'h0000, s[16]};
		end
		read_sum();
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		read_sum();
		t_carry();
		t_verify();
		t_burst();
		close_out();
	end
endmodule // ones_complement_checksum_adder_tb
`default_nettype wire
